// ### bench/pif_src_model.sv
// Model of the event sources, peripheral owners and port pins of the flag block.
// Assumes a shared ref_clk; all strobes change 10 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module pif_src_model
  import pif_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Strobes towards the flag block
  output var pif_evt_t evt,
  output var pif_side_t side,
  // Port pins
  output logic [8:0] port_pin
);
  initial begin
    evt = '0;
    side = '0;
    port_pin = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle event and side-effect pulses
  task automatic fire(input pif_evt_t e, input pif_side_t s);
    @(posedge ref_clk);
    #10;
    evt = e;
    side = s;
    @(posedge ref_clk);
    #10;
    evt = '0;
    side = '0;
  endtask : fire

  // Pins settle away from the clock edge
  task automatic pins(input logic [8:0] p);
    @(posedge ref_clk);
    #10;
    port_pin = p;
  endtask : pins
endmodule : pif_src_model
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench of the peripheral interrupt status flags.
// Assumes pif_flags and pif_src_model; one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pif_pkg::*;
  logic ref_clk;
  logic reset;
  pif_bus_t sfr_bus;
  pif_bus_t sec_bus;
  logic [7:0] sfr_rdata;
  logic [7:0] sec_rdata;
  logic [7:0] pe;
  logic [7:0] pst;
  logic [7:0] lv;
  logic [8:0] route;
  pif_evt_t evt;
  pif_side_t side;
  logic [8:0] port_pin;
  int fail_count;
  int checks;

  pif_flags DUT (.ref_clk(ref_clk), .reset(reset), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata),
    .sec_bus(sec_bus), .sec_rdata(sec_rdata), .evt(evt), .side(side), .port_pin(port_pin),
    .peripheral_irq_status(pe), .port_irq_status(pst), .low_voltage_irq_status(lv), .port_route_en(route));
  pif_src_model u_src (.ref_clk(ref_clk), .evt(evt), .side(side), .port_pin(port_pin));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic sec, input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    pif_bus_t b;
    b = '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk);
    #10;
    if (sec) sec_bus = b;
    else sfr_bus = b;
    @(posedge ref_clk);
    #10;
    sec_bus = '0;
    sfr_bus = '0;
    q = sec ? sec_rdata : sfr_rdata;
  endtask : xfer

  task automatic wr(input logic sec, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(sec, 1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic sec, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(sec, 1'b0, a, 8'h00, q);
    chk({1'b0, q}, {1'b0, exp});
  endtask : rdc

  task automatic settle();
    repeat (5) @(posedge ref_clk);
    #10;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] rv [7];
    rv = '{8'h10, 8'h00, 8'h80, 8'h00, 8'h00, 8'h55, 8'h01};
    for (int i = 0; i < 7; i++) rdc(1'b1, 8'h34 + 8'(i), rv[i]);
    rdc(1'b0, 8'hae, 8'h00);
    rdc(1'b0, 8'hc7, 8'h00);
    rdc(1'b0, 8'hd5, 8'h00);
    rdc(1'b0, 8'h00, 8'h00);
    rdc(1'b1, 8'h40, 8'h00);
    wr(1'b1, 8'h37, 8'hff);
    rdc(1'b1, 8'h37, 8'h87);
    wr(1'b1, 8'h37, 8'h00);
  endtask : t_reset

  task automatic t_events();
    int pb [7];
    pb = '{7, 6, 4, 3, 2, 1, 0};
    for (int i = 0; i < 7; i++) begin
      u_src.fire(pif_evt_t'(9'h100 >> i), '0);
      chk({1'b0, pe}, 9'(1 << pb[i]));
      wr(1'b0, 8'hae, 8'hff);
      chk({1'b0, pe}, 9'(1 << pb[i]));
      wr(1'b0, 8'hae, ~8'(1 << pb[i]));
      chk({1'b0, pe}, 9'h000);
    end
  endtask : t_events

  task automatic t_side();
    logic [7:0] m [6];
    m = '{8'h03, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80};
    for (int j = 0; j < 6; j++) begin
      u_src.fire(pif_evt_t'(9'h1fc), '0);
      u_src.fire('0, pif_side_t'(6'(1 << j)));
      chk({1'b0, pe}, {1'b0, 8'hdf & ~m[j]});
      wr(1'b0, 8'hae, 8'h00);
    end
    fork
      wr(1'b0, 8'hae, 8'h00);
      u_src.fire(pif_evt_t'(9'h040), '0);
    join
    chk({1'b0, pe}, 9'h010);
    wr(1'b0, 8'hae, 8'h00);
    rdc(1'b0, 8'hae, 8'h00);
  endtask : t_side

  task automatic t_lv();
    u_src.fire(pif_evt_t'(9'h003), '0);
    rdc(1'b0, 8'hd5, 8'h03);
    wr(1'b0, 8'hd5, 8'h02);
    rdc(1'b0, 8'hd5, 8'h02);
    wr(1'b0, 8'hd5, 8'h00);
    chk({1'b0, lv}, 9'h000);
  endtask : t_lv

  task automatic t_ports();
    wr(1'b1, 8'h39, 8'h56);
    rdc(1'b1, 8'h39, 8'h56);
    wr(1'b1, 8'h35, 8'hff);
    chk(route, 9'h0ff);
    u_src.pins(9'h0a5);
    settle();
    chk({1'b0, pst}, 9'h0a5);
    wr(1'b1, 8'h35, 8'hfe);
    u_src.pins(9'h000);
    settle();
    chk({1'b0, pst}, 9'h0a4);
    wr(1'b0, 8'hc7, 8'h00);
    wr(1'b1, 8'h39, 8'h55);
    u_src.pins(9'h0ff);
    settle();
    chk({1'b0, pst}, 9'h000);
    u_src.pins(9'h000);
    settle();
    chk({1'b0, pst}, 9'h0fe);
    wr(1'b0, 8'hc7, 8'h00);
    wr(1'b1, 8'h39, 8'h54);
    wr(1'b1, 8'h34, 8'h11);
    chk(route, 9'h1fe);
    u_src.pins(9'h103);
    settle();
    chk({pe[5], pst}, 9'h102);
    wr(1'b0, 8'hc7, 8'h00);
    wr(1'b0, 8'hae, 8'hdf);
    wr(1'b1, 8'h39, 8'h57);
    u_src.pins(9'h000);
    settle();
    chk({pe[5], pst}, 9'h102);
    wr(1'b1, 8'h34, 8'h10);
    chk({pe[5], route[8]}, 9'h000);
    wr(1'b1, 8'h35, 8'h00);
    chk({1'b0, pst}, 9'h000);
    chk(route, 9'h000);
  endtask : t_ports

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  initial begin
    #300000;
    fail_count++;
    test_done();
  end

  initial begin
    fail_count = 0;
    checks = 0;
    reset = 1'b1;
    sfr_bus = '0;
    sec_bus = '0;
    repeat (6) @(posedge ref_clk);
    #10;
    reset = 1'b0;
    t_reset();
    t_events();
    t_side();
    t_lv();
    t_ports();
    test_done();
  end
endmodule : tb_top
`default_nettype wire

// ### verilog/pif_defines.svh
// Constants of the peripheral interrupt status flag block.
// Assumes an 8-bit special function register port and an 8-bit secondary bus.
`ifndef PIF_DEFINES_SVH
`define PIF_DEFINES_SVH

// Special function register addresses
`define PIF_ADDR_PE 8'hae
`define PIF_ADDR_PORT 8'hc7
`define PIF_ADDR_LV 8'hd5

// Secondary bus addresses
`define PIF_ADDR_SEL1 8'h34
`define PIF_ADDR_SEL2 8'h35
`define PIF_ADDR_SEL3 8'h36
`define PIF_ADDR_SEL4 8'h37
`define PIF_ADDR_SEL5 8'h38
`define PIF_ADDR_CFG1 8'h39
`define PIF_ADDR_CFG2 8'h3a

// Reset values
`define PIF_RST_SEL1 8'h10
`define PIF_RST_SEL2 8'h00
`define PIF_RST_SEL3 8'h80
`define PIF_RST_SEL4 8'h00
`define PIF_RST_SEL5 8'h00
`define PIF_RST_CFG1 8'h55
`define PIF_RST_CFG2 8'h01
`define PIF_RST_FLAGS 8'h00

// Implemented bits; the rest read as zero
`define PIF_MASK_SEL3 8'h80
`define PIF_MASK_SEL4 8'h87
`define PIF_MASK_SEL5 8'h7f
`define PIF_MASK_CFG2 8'h07
`define PIF_MASK_LV 8'h03

// Field positions
`define PIF_BIT_PGB 7
`define PIF_BIT_TMC 6
`define PIF_BIT_P8 5
`define PIF_BIT_WDT 4
`define PIF_BIT_TMB 3
`define PIF_BIT_PGA 2
`define PIF_BIT_LCD 1
`define PIF_BIT_LED 0
`define PIF_BIT_RISE 1
`define PIF_BIT_FALL 0
`define PIF_BIT_SEL1_P8 0
`define PIF_PIN_P8 8

// Trigger polarity codes
`define PIF_POL_FALL 2'b01
`define PIF_POL_RISE 2'b10

`endif

// ### verilog/pif_flags.sv
// Peripheral and port interrupt status flags with the port select registers.
// Assumes event and side-effect strobes come from logic on ref_clk;
// port pins are asynchronous and are synchronised here.
//
// Overview of operation
// R1: Pulse group B event sets bit 7; write 0 or channel off clears it.
// R2: Timer C event sets bit 6; write 0 or timer C config write clears.
// R3: Port eight event sets bit 5; write 0 or its select written 0 clears.
// R4: Watchdog event sets bit 4; write 0 or watchdog control write clears.
// R5: Timer B event sets bit 3; write 0 or timer B config write clears.
// R6: Pulse group A event sets bit 2; write 0 or channel off clears it.
// R7: LCD scan event sets bit 1; write 0 or scan-start write clears it.
// R8: LED scan event sets bit 0; write 0 or scan-start write clears it.
// R9: Port status holds ports 7..0; write 0 or select written 0 clears.
// R10: A flag reads 1 while pending; writing 0 to it clears it.
// R11: Low-voltage status: bit 1 supply rise, bit 0 supply fall, rest zero.
// R12: Select and trigger config registers sit on secondary bus 0x34..0x3a.
// R13: Polarity field: 01 falling, 10 rising, 00 or 11 both edges.
// R14: A select enable of 1 routes its pin to the interrupt, 0 disconnects.
// R15: A set in the same cycle as a clear leaves the flag set.
`timescale 1ns/1ps
`default_nettype none
`include "pif_defines.svh"

module pif_flags
  import pif_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Special function register port
  input wire pif_bus_t sfr_bus,
  output logic [7:0] sfr_rdata,
  // Secondary bus
  input wire pif_bus_t sec_bus,
  output logic [7:0] sec_rdata,
  // Event sources and owner side effects
  input wire pif_evt_t evt,
  input wire pif_side_t side,
  // Port pins, bit 8 is port eight
  input wire logic [8:0] port_pin,
  // Flag and routing state
  output logic [7:0] peripheral_irq_status,
  output logic [7:0] port_irq_status,
  output logic [7:0] low_voltage_irq_status,
  output logic [8:0] port_route_en
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic pif_trig(input logic [1:0] pol, input logic prev, input logic cur);
    case (pol)
      `PIF_POL_FALL: pif_trig = prev & ~cur;
      `PIF_POL_RISE: pif_trig = ~prev & cur;
      default: pif_trig = prev ^ cur;
    endcase
  endfunction : pif_trig

  function automatic logic pif_hit(input pif_bus_t bus, input logic [7:0] addr);
    pif_hit = bus.wr && (bus.addr == addr);
  endfunction : pif_hit

  pif_state_t s;
  pif_state_t next_s;
  logic [8:0] hit;
  logic [7:0] pe_set;
  logic [7:0] pe_clr;
  logic [7:0] port_clr;
  logic [1:0] lv_set;
  logic [1:0] lv_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing and edge detection

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_port
      if (gi == `PIF_PIN_P8) begin : g_eight
        assign port_route_en[gi] = s.sel1[`PIF_BIT_SEL1_P8]; // see R14
      end else begin : g_low
        assign port_route_en[gi] = s.sel2[gi]; // see R14
      end
      // All port inputs share the group trigger field
      assign hit[gi] = port_route_en[gi] && pif_trig(s.cfg1[1:0], s.pin_last[gi], s.pin_sync[gi]); // see R13
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Set and clear terms

  always_comb begin
    pe_set = {evt.pulse_group_b, evt.timer_c, hit[`PIF_PIN_P8], evt.watchdog,
              evt.timer_b, evt.pulse_group_a, evt.lcd_scan, evt.led_scan};
    lv_set = {evt.supply_rise, evt.supply_fall};
    pe_clr = 8'h00;
    port_clr = 8'h00;
    lv_clr = 2'b00;
    if (pif_hit(sfr_bus, `PIF_ADDR_PE)) begin
      pe_clr = ~sfr_bus.wdata; // see R10
    end
    if (pif_hit(sfr_bus, `PIF_ADDR_PORT)) begin
      port_clr = ~sfr_bus.wdata; // see R9
    end
    if (pif_hit(sfr_bus, `PIF_ADDR_LV)) begin
      lv_clr = ~sfr_bus.wdata[1:0]; // see R11
    end
    if (side.pulse_group_b_off) begin
      pe_clr[`PIF_BIT_PGB] = 1'b1; // see R1
    end
    if (side.timer_c_config_wr) begin
      pe_clr[`PIF_BIT_TMC] = 1'b1; // see R2
    end
    if (pif_hit(sec_bus, `PIF_ADDR_SEL1) && !sec_bus.wdata[`PIF_BIT_SEL1_P8]) begin
      pe_clr[`PIF_BIT_P8] = 1'b1; // see R3
    end
    if (side.watchdog_control_wr) begin
      pe_clr[`PIF_BIT_WDT] = 1'b1; // see R4
    end
    if (side.timer_b_config_wr) begin
      pe_clr[`PIF_BIT_TMB] = 1'b1; // see R5
    end
    if (side.pulse_group_a_off) begin
      pe_clr[`PIF_BIT_PGA] = 1'b1; // see R6
    end
    if (side.scan_start_wr) begin
      pe_clr[`PIF_BIT_LCD] = 1'b1; // see R7
      pe_clr[`PIF_BIT_LED] = 1'b1; // see R8
    end
    if (pif_hit(sec_bus, `PIF_ADDR_SEL2)) begin
      port_clr = port_clr | ~sec_bus.wdata; // see R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    next_s.pin_meta = port_pin;
    next_s.pin_sync = s.pin_meta;
    next_s.pin_last = s.pin_sync;
    // Set terms are ORed after the clear so an event is never lost
    next_s.pe = (s.pe & ~pe_clr) | pe_set; // see R15
    next_s.port = (s.port & ~port_clr) | hit[7:0]; // see R15
    next_s.lv = (s.lv & ~lv_clr) | lv_set; // see R15
    if (sec_bus.wr) begin
      case (sec_bus.addr) // see R12
        `PIF_ADDR_SEL1: next_s.sel1 = sec_bus.wdata;
        `PIF_ADDR_SEL2: next_s.sel2 = sec_bus.wdata;
        `PIF_ADDR_SEL3: next_s.sel3 = sec_bus.wdata & `PIF_MASK_SEL3;
        `PIF_ADDR_SEL4: next_s.sel4 = sec_bus.wdata & `PIF_MASK_SEL4;
        `PIF_ADDR_SEL5: next_s.sel5 = sec_bus.wdata & `PIF_MASK_SEL5;
        `PIF_ADDR_CFG1: next_s.cfg1 = sec_bus.wdata;
        `PIF_ADDR_CFG2: next_s.cfg2 = sec_bus.wdata & `PIF_MASK_CFG2;
        default: next_s.cfg2 = s.cfg2;
      endcase
    end
    if (sfr_bus.rd) begin
      case (sfr_bus.addr)
        `PIF_ADDR_PE: next_s.sfr_rdata = s.pe; // see R10
        `PIF_ADDR_PORT: next_s.sfr_rdata = s.port; // see R9
        `PIF_ADDR_LV: next_s.sfr_rdata = {6'h00, s.lv}; // see R11
        default: next_s.sfr_rdata = 8'h00;
      endcase
    end
    if (sec_bus.rd) begin
      case (sec_bus.addr) // see R12
        `PIF_ADDR_SEL1: next_s.sec_rdata = s.sel1;
        `PIF_ADDR_SEL2: next_s.sec_rdata = s.sel2;
        `PIF_ADDR_SEL3: next_s.sec_rdata = s.sel3;
        `PIF_ADDR_SEL4: next_s.sec_rdata = s.sel4;
        `PIF_ADDR_SEL5: next_s.sec_rdata = s.sel5;
        `PIF_ADDR_CFG1: next_s.sec_rdata = s.cfg1;
        `PIF_ADDR_CFG2: next_s.sec_rdata = s.cfg2;
        default: next_s.sec_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s.pe <= `PIF_RST_FLAGS;
      s.port <= `PIF_RST_FLAGS;
      s.lv <= 2'b00;
      s.sel1 <= `PIF_RST_SEL1;
      s.sel2 <= `PIF_RST_SEL2;
      s.sel3 <= `PIF_RST_SEL3;
      s.sel4 <= `PIF_RST_SEL4;
      s.sel5 <= `PIF_RST_SEL5;
      s.cfg1 <= `PIF_RST_CFG1;
      s.cfg2 <= `PIF_RST_CFG2;
      s.pin_meta <= 9'h000;
      s.pin_sync <= 9'h000;
      s.pin_last <= 9'h000;
      s.sfr_rdata <= 8'h00;
      s.sec_rdata <= 8'h00;
    end else begin
      s <= next_s;
    end
  end

  assign sfr_rdata = s.sfr_rdata;
  assign sec_rdata = s.sec_rdata;
  assign peripheral_irq_status = s.pe;
  assign port_irq_status = s.port;
  assign low_voltage_irq_status = {6'h00, s.lv} & `PIF_MASK_LV;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_pgb;
    (evt.pulse_group_b |=> peripheral_irq_status[7]) and
    (side.pulse_group_b_off && !evt.pulse_group_b |=> !peripheral_irq_status[7]);
  endproperty
  a_pgb: assert property (p_pgb) else $error("pulse group b flag wrong"); // see R1

  property p_tmc;
    side.timer_c_config_wr && !evt.timer_c |=> !peripheral_irq_status[6];
  endproperty
  a_tmc: assert property (p_tmc) else $error("timer c flag not cleared"); // see R2

  property p_p8;
    pif_hit(sec_bus, 8'h34) && !sec_bus.wdata[0] && !hit[8] |=> !peripheral_irq_status[5];
  endproperty
  a_p8: assert property (p_p8) else $error("port eight flag not cleared"); // see R3

  property p_wdt;
    side.watchdog_control_wr && !evt.watchdog |=> !peripheral_irq_status[`PIF_BIT_WDT];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog flag wrong"); // see R4

  property p_tmb;
    side.timer_b_config_wr && !evt.timer_b |=> !peripheral_irq_status[3];
  endproperty
  a_tmb: assert property (p_tmb) else $error("timer b flag not cleared"); // see R5

  property p_pga;
    side.pulse_group_a_off && !evt.pulse_group_a |=> !peripheral_irq_status[2];
  endproperty
  a_pga: assert property (p_pga) else $error("pulse group a flag not cleared"); // see R6

  property p_scan;
    side.scan_start_wr && !evt.lcd_scan && !evt.led_scan |=> peripheral_irq_status[1:0] == 2'b00;
  endproperty
  a_scan: assert property (p_scan) else $error("scan flags not cleared"); // see R7

  property p_led_hold;
    peripheral_irq_status[0] && !side.scan_start_wr && !(pif_hit(sfr_bus, 8'hae) && !sfr_bus.wdata[0])
      |=> peripheral_irq_status[0];
  endproperty
  a_led_hold: assert property (p_led_hold) else $error("led flag lost"); // see R8

  property p_port_sel;
    pif_hit(sec_bus, 8'h35) && sec_bus.wdata == 8'h00 && hit[7:0] == 8'h00 |=> port_irq_status == 8'h00;
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("port flags not cleared"); // see R9

  sequence s_pe_write_zero;
    pif_hit(sfr_bus, `PIF_ADDR_PE) && sfr_bus.wdata == 8'h00 && pe_set == 8'h00;
  endsequence
  sequence s_pe_read;
    sfr_bus.rd && sfr_bus.addr == `PIF_ADDR_PE;
  endsequence
  property p_write_zero;
    s_pe_write_zero ##1 (pe_set == 8'h00) ##1 s_pe_read |=> sfr_rdata == 8'h00;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write 0 did not clear"); // see R10

  property p_lv;
    (evt.supply_rise |=> low_voltage_irq_status[1]) and
    (sfr_bus.rd && sfr_bus.addr == 8'hd5 |=> sfr_rdata[7:2] == 6'h00);
  endproperty
  a_lv: assert property (p_lv) else $error("low voltage status wrong"); // see R11

  sequence s_cfg_write;
    pif_hit(sec_bus, `PIF_ADDR_CFG1) && !sfr_bus.wr;
  endsequence
  property p_sec;
    s_cfg_write ##1 !sec_bus.wr ##1 (sec_bus.rd && sec_bus.addr == `PIF_ADDR_CFG1 && !sec_bus.wr)
      |=> sec_rdata == $past(sec_bus.wdata, 3);
  endproperty
  a_sec: assert property (p_sec) else $error("secondary register readback wrong"); // see R12

  property p_rise;
    s.cfg1[1:0] == 2'b10 && s.sel2[0] && !s.pin_last[0] && s.pin_sync[0] |=> port_irq_status[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed"); // see R13

  property p_fall_only;
    s.cfg1[1:0] == 2'b01 && !port_irq_status[0] && !s.pin_last[0] && s.pin_sync[0] |=> !port_irq_status[0];
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("rising edge taken on falling trigger"); // see R13

  property p_route;
    !port_route_en[3] && !port_irq_status[3] |=> !port_irq_status[3];
  endproperty
  a_route: assert property (p_route) else $error("disconnected pin set a flag"); // see R14

  property p_set_wins;
    evt.watchdog && pif_hit(sfr_bus, 8'hae) && !sfr_bus.wdata[4] |=> peripheral_irq_status[4];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under clear"); // see R15

  property p_tmc_set;
    evt.timer_c |=> peripheral_irq_status[`PIF_BIT_TMC];
  endproperty
  a_tmc_set: assert property (p_tmc_set) else $error("timer c event lost"); // see R2

  property p_p8_set;
    hit[`PIF_PIN_P8] |=> peripheral_irq_status[`PIF_BIT_P8];
  endproperty
  a_p8_set: assert property (p_p8_set) else $error("port eight edge lost"); // see R3

  property p_port_write_zero;
    pif_hit(sfr_bus, `PIF_ADDR_PORT) && sfr_bus.wdata == 8'h00 && hit[7:0] == 8'h00
      |=> port_irq_status == 8'h00;
  endproperty
  a_port_write_zero: assert property (p_port_write_zero) else $error("port flags not cleared by write"); // see R9

  property p_write_one;
    pif_hit(sfr_bus, `PIF_ADDR_PE) && pe_set == 8'h00
      |=> (peripheral_irq_status & ~$past(peripheral_irq_status)) == 8'h00;
  endproperty
  a_write_one: assert property (p_write_one) else $error("flag set by a write"); // see R10

  property p_lv_fall;
    evt.supply_fall |=> low_voltage_irq_status[`PIF_BIT_FALL];
  endproperty
  a_lv_fall: assert property (p_lv_fall) else $error("supply fall event lost"); // see R11

  property p_sec_unmapped;
    sec_bus.rd && (sec_bus.addr < `PIF_ADDR_SEL1 || sec_bus.addr > `PIF_ADDR_CFG2) |=> sec_rdata == 8'h00;
  endproperty
  a_sec_unmapped: assert property (p_sec_unmapped) else $error("unmapped secondary read not zero"); // see R12

  property p_both_edges;
    s.cfg1[1:0] != `PIF_POL_FALL && s.cfg1[1:0] != `PIF_POL_RISE && s.sel2[1] && s.pin_last[1] && !s.pin_sync[1]
      |=> port_irq_status[1];
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("falling edge missed on both-edge trigger"); // see R13

  property p_route_eight;
    pif_hit(sec_bus, `PIF_ADDR_SEL1) |=> port_route_en[`PIF_PIN_P8] == $past(sec_bus.wdata[`PIF_BIT_SEL1_P8]);
  endproperty
  a_route_eight: assert property (p_route_eight) else $error("port eight routing wrong"); // see R14

  property p_route_low;
    pif_hit(sec_bus, `PIF_ADDR_SEL2) |=> port_route_en[7:0] == $past(sec_bus.wdata);
  endproperty
  a_route_low: assert property (p_route_low) else $error("port routing wrong"); // see R14

endmodule : pif_flags
`default_nettype wire

// ### verilog/pif_pkg.sv
// Types of the peripheral interrupt status flag block.
// Assumes one clock domain shared with the core and the event sources.
`default_nettype none
package pif_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pif_bus_t;

  typedef struct packed {
    logic pulse_group_b;
    logic timer_c;
    logic watchdog;
    logic timer_b;
    logic pulse_group_a;
    logic lcd_scan;
    logic led_scan;
    logic supply_rise;
    logic supply_fall;
  } pif_evt_t;

  typedef struct packed {
    logic pulse_group_b_off;
    logic timer_c_config_wr;
    logic watchdog_control_wr;
    logic timer_b_config_wr;
    logic pulse_group_a_off;
    logic scan_start_wr;
  } pif_side_t;

  typedef struct packed {
    logic [7:0] pe;
    logic [7:0] port;
    logic [1:0] lv;
    logic [7:0] sel1;
    logic [7:0] sel2;
    logic [7:0] sel3;
    logic [7:0] sel4;
    logic [7:0] sel5;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [8:0] pin_meta;
    logic [8:0] pin_sync;
    logic [8:0] pin_last;
    logic [7:0] sfr_rdata;
    logic [7:0] sec_rdata;
  } pif_state_t;

endpackage : pif_pkg
`default_nettype wire
